/* design/cft_pkg.sv */
package cft_pkg;
  localparam int CLK_MHZ      = 50;
  localparam int RESP_W       = 13;
  localparam int FS_CODE      = 1024;
  localparam int CFG_W        = 26;
  localparam int TEMP_W       = 12;
  localparam int QCNT_W       = 10;
  localparam int ADDR_W       = 12;
  // printed offsets are register indexes; byte address is index times four
  localparam logic [ADDR_W-1:0] IDX_CUST0  = 12'h019;
  localparam logic [ADDR_W-1:0] IDX_CUST1  = 12'h01a;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 12'h020;
  localparam logic [ADDR_W-1:0] ADDR_CUST0  = IDX_CUST0 << 2;
  localparam logic [ADDR_W-1:0] ADDR_CUST1  = IDX_CUST1 << 2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = IDX_STATUS << 2;
  // word 0 fields
  localparam int C0_SNS_LSB = 0;
  localparam int C0_QVO_LSB = 9;
  localparam int TRIM_W     = 9;
  localparam int C0_FDIS    = 19;
  localparam int C0_POL     = 21;
  localparam int C0_OTFDIS  = 22;
  // word 1 fields
  localparam int C1_PTHR_LSB = 0;
  localparam int C1_NTHR_LSB = 7;
  localparam int THR_W       = 7;
  localparam int C1_QUAL_LSB = 18;
  localparam int QUAL_W      = 3;
  localparam int C1_NDIS     = 21;
  localparam int C1_PDIS     = 22;
  localparam int C1_LATCH    = 23;
  localparam int C1_HYST_LSB = 24;
  localparam int HYST_W      = 2;
  // status fields
  localparam int ST_FP_EV   = 0;
  localparam int ST_OT_EV   = 1;
  localparam int ST_OC_EV   = 2;
  localparam int ST_FP_STAT = 8;
  localparam int ST_OT_STAT = 9;
  localparam int ST_OC_STAT = 10;
  localparam int ST_TEMP_LSB = 16;
  localparam logic [CFG_W-1:0] CUST0_RST = 26'h0200000;
  localparam logic [CFG_W-1:0] CUST1_RST = 26'h0000000;
  localparam int THR_MIN_PCT   = 50;
  localparam int THR_MAX_PCT   = 200;
  localparam int THR_CODE_MAX  = 127;
  localparam int HYST_FLOOR_PCT = 25;
  localparam int QUAL_NS [8]  = '{2300, 2900, 5000, 7600, 10100, 12600, 15300, 17900};
  localparam int HYST_PCT [4] = '{11, 22, 42, 75};

  typedef enum logic [1:0] {LD_RESET, LD_COPY, LD_RUN} cft_load_type;

  // least delay rounds up to whole cycles
  function automatic logic [QCNT_W-1:0] cft_qual_cycles(input logic [QUAL_W-1:0] code);
    cft_qual_cycles = QCNT_W'((QUAL_NS[code] * CLK_MHZ + 999) / 1000);
  endfunction

  function automatic logic signed [RESP_W-1:0] cft_thr_level(input logic [THR_W-1:0] code);
    int pct;
    pct = THR_MIN_PCT * THR_CODE_MAX + int'(code) * (THR_MAX_PCT - THR_MIN_PCT);
    cft_thr_level = RESP_W'(pct * FS_CODE / (THR_CODE_MAX * 100));
  endfunction

  function automatic logic signed [RESP_W-1:0] cft_rel_level(input logic [THR_W-1:0] thrCode,
                                                            input logic [HYST_W-1:0] hystCode);
    int thr;
    int hyst;
    int cap;
    thr  = int'(cft_thr_level(thrCode));
    hyst = HYST_PCT[hystCode] * FS_CODE / 100;
    cap  = thr - HYST_FLOOR_PCT * FS_CODE / 100;
    if (hyst > cap) begin
      hyst = cap;
    end
    cft_rel_level = RESP_W'(thr - hyst);
  endfunction
endpackage

/* design/cft_side_if.sv */
`timescale 1ns/1ps
interface cft_side_if;
  import cft_pkg::*;
  logic                     enable;
  logic signed [RESP_W-1:0] level;
  logic signed [RESP_W-1:0] thrLevel;
  logic signed [RESP_W-1:0] relLevel;
  logic [QCNT_W-1:0]        qualCycles;
  logic                     trip;
  modport ctrl (output enable, output level, output thrLevel, output relLevel, output qualCycles, input trip);
  modport det  (input enable, input level, input thrLevel, input relLevel, input qualCycles, output trip);
endinterface

/* design/cft_trim.sv */
`timescale 1ns/1ps
module cft_trim
  import cft_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic signed [RESP_W-1:0] rawSample,
  input  wire logic [TRIM_W-1:0]        sensFine,
  input  wire logic [TRIM_W-1:0]        qvoTrim,
  input  wire logic                     outDir,
  output logic signed [RESP_W-1:0]      resp,
  output logic signed [RESP_W:0]        analogOutputCode
);
  logic signed [RESP_W-1:0]  dirSample;
  logic signed [TRIM_W+1:0]  gain;
  logic signed [RESP_W+TRIM_W+1:0] prod;

  always_comb begin
    dirSample = outDir ? rawSample : -rawSample;
    gain      = (TRIM_W+2)'(signed'(sensFine)) + (TRIM_W+2)'(1 << TRIM_W);
    prod      = dirSample * gain;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resp <= '0;
    end else begin
      resp <= prod[RESP_W+TRIM_W-1:TRIM_W];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      analogOutputCode <= '0;
    end else begin
      analogOutputCode <= (RESP_W+1)'(resp) + (RESP_W+1)'(signed'(qvoTrim));
    end
  end

  a_trim_unity: assert property (@(posedge clk) disable iff (rst)
    (sensFine == '0 && outDir) |=> resp == $past(rawSample))
    else $error("unity trim does not pass the sample");
endmodule // cft_trim

/* design/cft_side_det.sv */
`timescale 1ns/1ps
module cft_side_det
  import cft_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  cft_side_if.det   side
);
  logic [QCNT_W-1:0] qualCnt_r;
  logic              over;

  assign over = side.enable && (side.level > side.thrLevel);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qualCnt_r <= '0;
    end else if (!over) begin
      qualCnt_r <= '0;
    end else if (qualCnt_r != side.qualCycles) begin
      qualCnt_r <= qualCnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      side.trip <= 1'b0;
    end else if (!side.enable) begin
      side.trip <= 1'b0;
    end else if (!side.trip && over && qualCnt_r == side.qualCycles - 1'b1) begin
      side.trip <= 1'b1;
    end else if (side.trip && side.level < side.relLevel) begin
      side.trip <= 1'b0;
    end
  end

  sequence sQualified;
    over && qualCnt_r == side.qualCycles - 1'b1;
  endsequence

  a_qual_trip: assert property (@(posedge clk) disable iff (rst)
    $rose(side.trip) |-> $past(over) && $past(qualCnt_r) == $past(side.qualCycles) - 1'b1)
    else $error("trip rose before the qualifier count");
  a_qual_reach: assert property (@(posedge clk) disable iff (rst)
    sQualified |=> side.trip)
    else $error("qualified excursion did not trip");
  a_cnt_restart: assert property (@(posedge clk) disable iff (rst)
    !over |=> qualCnt_r == '0)
    else $error("qualifier count survived a drop");
  a_side_release: assert property (@(posedge clk) disable iff (rst)
    side.trip && side.level < side.relLevel |=> !side.trip)
    else $error("release took longer than one cycle");
  a_side_off: assert property (@(posedge clk) disable iff (rst)
    !side.enable |=> !side.trip)
    else $error("disabled side tripped");
endmodule // cft_side_det

/* design/cft_top.sv */
`timescale 1ns/1ps
module cft_top
  import cft_pkg::*;
#(
  parameter bit BIDIR = 1'b1
)(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [CFG_W-1:0]         nvmCust0,
  input  wire logic [CFG_W-1:0]         nvmCust1,
  input  wire logic signed [RESP_W-1:0] fieldSample,
  input  wire logic [TEMP_W-1:0]        tempCode,
  input  wire logic                     overTemp,
  output logic signed [RESP_W:0]        analogOutputCode,
  output logic                          faultL
);
  cft_load_type              loadState_r;
  logic [CFG_W-1:0]          cust0_r;
  logic [CFG_W-1:0]          cust1_r;
  logic                      faultHeld_r;
  logic                      ocEv_r;
  logic                      otEv_r;
  logic                      fpEv_r;
  logic [31:0]               rdata_nxt;
  logic                      rdErr_nxt;
  logic                      setup;
  logic                      access;
  logic                      wrCust0;
  logic                      wrCust1;
  logic                      rdStatus;
  logic                      running;
  logic signed [RESP_W-1:0]  resp;
  logic                      ocTrip;
  logic                      otTrip;
  logic                      faultNow;
  logic                      faultActive;

  cft_side_if posSide ();
  cft_side_if negSide ();

  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign pready  = 1'b1;
  assign wrCust0 = access && pwrite && paddr == ADDR_CUST0;
  assign wrCust1 = access && pwrite && paddr == ADDR_CUST1;
  assign running = loadState_r == LD_RUN;

  // startup copy of non-volatile words into the shadow registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loadState_r <= LD_RESET;
    end else begin
      case (loadState_r)
        LD_RESET: loadState_r <= LD_COPY;
        LD_COPY:  loadState_r <= LD_RUN;
        default:  loadState_r <= LD_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cust0_r <= CUST0_RST;
    end else if (loadState_r == LD_COPY) begin
      cust0_r <= nvmCust0;
    end else if (running && wrCust0) begin
      cust0_r <= pwdata[CFG_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cust1_r <= CUST1_RST;
    end else if (loadState_r == LD_COPY) begin
      cust1_r <= nvmCust1;
    end else if (running && wrCust1) begin
      cust1_r <= pwdata[CFG_W-1:0];
    end
  end

  cft_trim u_trim (
    .clk              (clk),
    .rst              (rst),
    .rawSample        (fieldSample),
    .sensFine         (cust0_r[C0_SNS_LSB +: TRIM_W]),
    .qvoTrim          (cust0_r[C0_QVO_LSB +: TRIM_W]),
    .outDir           (cust0_r[C0_POL]),
    .resp             (resp),
    .analogOutputCode (analogOutputCode)
  );

  // both sides see the same response each cycle; the negative side sees it negated
  always_comb begin
    posSide.enable     = running && !cust1_r[C1_PDIS];
    posSide.level      = resp;
    posSide.thrLevel   = cft_thr_level(cust1_r[C1_PTHR_LSB +: THR_W]);
    posSide.relLevel   = cft_rel_level(cust1_r[C1_PTHR_LSB +: THR_W], cust1_r[C1_HYST_LSB +: HYST_W]);
    posSide.qualCycles = cft_qual_cycles(cust1_r[C1_QUAL_LSB +: QUAL_W]);
  end

  always_comb begin
    negSide.enable     = running && BIDIR && !cust1_r[C1_NDIS];
    negSide.level      = -resp;
    negSide.thrLevel   = cft_thr_level(cust1_r[C1_NTHR_LSB +: THR_W]);
    negSide.relLevel   = cft_rel_level(cust1_r[C1_NTHR_LSB +: THR_W], cust1_r[C1_HYST_LSB +: HYST_W]);
    negSide.qualCycles = cft_qual_cycles(cust1_r[C1_QUAL_LSB +: QUAL_W]);
  end

  cft_side_det u_pos_det (
    .clk  (clk),
    .rst  (rst),
    .side (posSide.det)
  );

  cft_side_det u_neg_det (
    .clk  (clk),
    .rst  (rst),
    .side (negSide.det)
  );

  assign ocTrip   = posSide.trip || negSide.trip;
  assign otTrip   = running && overTemp && !cust0_r[C0_OTFDIS];
  assign faultNow = !cust0_r[C0_FDIS] && (ocTrip || otTrip);
  assign faultActive = faultNow || faultHeld_r;

  // only a power cycle, seen as reset, clears a held fault
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      faultHeld_r <= 1'b0;
    end else if (cust1_r[C1_LATCH] && faultNow) begin
      faultHeld_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      faultL <= 1'b1;
    end else begin
      faultL <= !faultActive;
    end
  end

  // read data is prepared in the setup cycle and shown in the access cycle
  always_comb begin
    rdata_nxt = '0;
    rdErr_nxt = 1'b0;
    if (paddr == ADDR_CUST0) begin
      rdata_nxt[CFG_W-1:0] = cust0_r;
    end else if (paddr == ADDR_CUST1) begin
      rdata_nxt[CFG_W-1:0] = cust1_r;
    end else if (paddr == ADDR_STATUS) begin
      rdata_nxt[ST_TEMP_LSB +: TEMP_W] = tempCode;
      rdata_nxt[ST_OC_STAT] = ocTrip;
      rdata_nxt[ST_OT_STAT] = otTrip;
      rdata_nxt[ST_FP_STAT] = !faultL;
      rdata_nxt[ST_OC_EV]   = ocEv_r;
      rdata_nxt[ST_OT_EV]   = otEv_r;
      rdata_nxt[ST_FP_EV]   = fpEv_r;
      rdErr_nxt = pwrite;
    end else begin
      rdErr_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rdata_nxt;
      pslverr <= rdErr_nxt;
    end
  end

  assign rdStatus = access && !pwrite && paddr == ADDR_STATUS;

  // events stick until a status read reports them; an event not yet in prdata is kept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ocEv_r <= 1'b0;
      otEv_r <= 1'b0;
      fpEv_r <= 1'b0;
    end else begin
      ocEv_r <= ocTrip || (ocEv_r && !(rdStatus && prdata[ST_OC_EV]));
      otEv_r <= otTrip || (otEv_r && !(rdStatus && prdata[ST_OT_EV]));
      fpEv_r <= !faultL || (fpEv_r && !(rdStatus && prdata[ST_FP_EV]));
    end
  end

  sequence sCopy;
    loadState_r == LD_COPY;
  endsequence

  a_startup_copy: assert property (@(posedge clk) disable iff (rst)
    sCopy |=> cust0_r == $past(nvmCust0) && cust1_r == $past(nvmCust1))
    else $error("shadow words not copied at startup");
  a_fault_low: assert property (@(posedge clk) disable iff (rst)
    faultActive |=> !faultL)
    else $error("fault pin not low during fault");
  a_fault_hold: assert property (@(posedge clk) disable iff (rst)
    faultHeld_r |=> faultHeld_r ##1 !faultL)
    else $error("held fault released");
  a_unidir_neg: assert property (@(posedge clk) disable iff (rst)
    !BIDIR |-> !negSide.trip)
    else $error("negative side active in unidirectional variant");
  a_hyst_cap: assert property (@(posedge clk) disable iff (rst)
    posSide.relLevel >= $signed(RESP_W'(HYST_FLOOR_PCT * FS_CODE / 100)))
    else $error("hysteresis exceeds its cap");
  a_pos_disable: assert property (@(posedge clk) disable iff (rst)
    cust1_r[C1_PDIS] ##1 cust1_r[C1_PDIS] |-> !posSide.trip)
    else $error("disabled positive side tripped");
endmodule // cft_top

/* verification/cft_fault_monitor.sv */
`timescale 1ns/1ps
module cft_fault_monitor (
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  faultL,
  output logic [15:0] fallCount_r
);
  logic lastL_r;

  // counts each high-to-low step of the fault line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lastL_r     <= 1'b1;
      fallCount_r <= 16'h0000;
    end else begin
      lastL_r <= faultL;
      if (lastL_r && !faultL) begin
        fallCount_r <= fallCount_r + 16'h0001;
      end
    end
  end
endmodule // cft_fault_monitor

/* verification/tb_current_fault_trim_logic.sv */
`timescale 1ns/1ps
module tb_current_fault_trim_logic;
  import cft_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, overTemp = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, faultL, faultUni, err;
  logic [CFG_W-1:0] nvm0 = 26'h0200005, nvm1 = 26'h0000000;
  logic signed [RESP_W-1:0] smp = '0;
  logic [TEMP_W-1:0] temp = 12'h92f;
  logic signed [RESP_W:0] aout;
  logic [15:0] falls;
  int failures = 0, tests_run = 0;

  always #10 clk = ~clk;

  cft_top #(.BIDIR(1'b1)) i_dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nvmCust0(nvm0),
    .nvmCust1(nvm1), .fieldSample(smp), .tempCode(temp), .overTemp(overTemp), .analogOutputCode(aout),
    .faultL(faultL));
  cft_top #(.BIDIR(1'b0)) i_uni (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .nvmCust0(nvm0),
    .nvmCust1(nvm1), .fieldSample(smp), .tempCode(temp), .overTemp(overTemp), .analogOutputCode(),
    .faultL(faultUni));
  cft_fault_monitor i_mon (.clk(clk), .rst(rst), .faultL(faultL), .fallCount_r(falls));

  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_cnt(input string nm, input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      failures++;
      $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  // one transfer, then an idle edge so back-to-back calls never collide
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      failures++;
      $display("MISMATCH apb ready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] cfg1(input int pt, nt, q, nd, pd, hl, hy);
    return 32'(pt) | 32'(nt) << C1_NTHR_LSB | 32'(q) << C1_QUAL_LSB | 32'(nd) << C1_NDIS
      | 32'(pd) << C1_PDIS | 32'(hl) << C1_LATCH | 32'(hy) << C1_HYST_LSB;
  endfunction

  function automatic logic [31:0] cfg0(input int sn, of, dr);
    return 32'(sn & 'h1ff) | 32'(of & 'h1ff) << C0_QVO_LSB | 32'(dr) << C0_POL;
  endfunction

  function automatic int qn(input int q);
    return (QUAL_NS[q] * CLK_MHZ + 999) / 1000;
  endfunction

  task automatic drive(input int v);
    @(posedge clk);
    smp <= RESP_W'(v);
  endtask

  // counts edges until the fault pin shows the wanted level
  task automatic wait_pin(input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (faultL !== lvl && n < 1000);
    if (faultL !== lvl) begin
      failures++;
      $display("MISMATCH fault pin wait expected %b seen %b", lvl, faultL);
    end
    // back on a rising edge so the next request starts right after it
    @(posedge clk);
  endtask

  task automatic t_regs;
    apb(ADDR_CUST0, 1'b0, 32'h0);
    chk_word("cust0", 32'(nvm0), rd);
    chk_word("ready", 32'h1, 32'(pready));
    apb(12'h0f0, 1'b0, 32'h0);
    chk_word("unmapped err", 32'h1, 32'(err));
    chk_word("unmapped data", 32'h0, rd);
    apb(ADDR_STATUS, 1'b1, 32'hffffffff);
    chk_word("status write err", 32'h1, 32'(err));
    apb(ADDR_CUST1, 1'b1, 32'hffffffff);
    apb(ADDR_CUST1, 1'b0, 32'h0);
    chk_word("cust1 rw", 32'h03ffffff, rd);
    apb(ADDR_CUST1, 1'b1, 32'h0);
  endtask

  task automatic t_trim;
    int sn[4] = '{0, 0, -256, 128};
    int of[4] = '{5, -5, 0, -3};
    int dr[4] = '{1, 1, 1, 0};
    int ex[4] = '{105, 95, 50, -128};
    for (int i = 0; i < 4; i++) begin
      apb(ADDR_CUST0, 1'b1, cfg0(sn[i], 0, dr[i]));
      apb(ADDR_CUST0, 1'b1, cfg0(sn[i], of[i], dr[i]));
      drive(100);
      repeat (4) @(posedge clk);
      chk_word("output code", 32'(ex[i]), 32'(aout));
    end
    drive(0);
    apb(ADDR_CUST0, 1'b1, cfg0(0, 0, 1));
  endtask

  task automatic t_qual;
    int n;
    logic [15:0] k;
    for (int q = 0; q < 8; q++) begin
      apb(ADDR_CUST1, 1'b1, cfg1(0, 0, q, 0, 0, 0, 0));
      k = falls;
      drive(600);
      repeat (qn(q) - 1) @(posedge clk);
      smp <= '0;
      repeat (5) @(posedge clk);
      chk_word("spike falls", 32'(k), 32'(falls));
      drive(600);
      wait_pin(1'b0, n);
      chk_cnt("assert edges", qn(q) + 2, n);
      chk_word("unidir pos", 32'h0, 32'(faultUni));
      drive(0);
      wait_pin(1'b1, n);
      chk_cnt("release edges", 3, n);
    end
  endtask

  task automatic t_hyst;
    int thr, hy, rel, n;
    thr = (THR_MIN_PCT * THR_CODE_MAX + 20 * (THR_MAX_PCT - THR_MIN_PCT)) * FS_CODE / (THR_CODE_MAX * 100);
    for (int h = 0; h < 4; h++) begin
      hy = HYST_PCT[h] * FS_CODE / 100;
      if (hy > thr - HYST_FLOOR_PCT * FS_CODE / 100) begin
        hy = thr - HYST_FLOOR_PCT * FS_CODE / 100;
      end
      rel = thr - hy;
      apb(ADDR_CUST1, 1'b1, cfg1(20, 0, 0, 0, 0, 0, h));
      drive(thr);
      repeat (130) @(posedge clk);
      chk_word("at threshold", 32'h1, 32'(faultL));
      drive(thr + 1);
      wait_pin(1'b0, n);
      chk_cnt("trip edges", qn(0) + 2, n);
      drive(rel);
      repeat (20) @(posedge clk);
      chk_word("at release level", 32'h0, 32'(faultL));
      drive(rel - 1);
      wait_pin(1'b1, n);
      chk_cnt("hyst release", 3, n);
    end
  endtask

  task automatic t_side;
    int n;
    apb(ADDR_CUST1, 1'b1, cfg1(0, 0, 0, 0, 0, 0, 0));
    drive(-600);
    wait_pin(1'b0, n);
    chk_cnt("neg assert", qn(0) + 2, n);
    chk_word("unidir neg", 32'h1, 32'(faultUni));
    drive(0);
    wait_pin(1'b1, n);
    apb(ADDR_CUST1, 1'b1, cfg1(0, 0, 0, 1, 1, 0, 0));
    drive(600);
    repeat (150) @(posedge clk);
    chk_word("pos disabled", 32'h1, 32'(faultL));
    drive(-600);
    repeat (150) @(posedge clk);
    chk_word("neg disabled", 32'h1, 32'(faultL));
    drive(0);
    apb(ADDR_CUST1, 1'b1, cfg1(0, 0, 0, 0, 1, 0, 0));
    apb(ADDR_CUST0, 1'b1, cfg0(0, 0, 0));
    drive(600);
    wait_pin(1'b0, n);
    chk_cnt("reversed trip", qn(0) + 2, n);
    drive(0);
    wait_pin(1'b1, n);
    apb(ADDR_CUST0, 1'b1, cfg0(0, 0, 0) | 32'h1 << C0_FDIS);
    drive(600);
    repeat (150) @(posedge clk);
    chk_word("fault disabled", 32'h1, 32'(faultL));
    drive(0);
    repeat (5) @(posedge clk);
    apb(ADDR_CUST0, 1'b1, cfg0(0, 0, 1));
  endtask

  task automatic t_latch;
    int n;
    apb(ADDR_CUST1, 1'b1, cfg1(0, 0, 0, 0, 0, 1, 0));
    drive(600);
    wait_pin(1'b0, n);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk_word("status", {4'h0, temp, 5'h00, 3'b101, 5'h00, 3'b101}, rd);
    chk_cnt("temp celsius", 36, (int'(rd[ST_TEMP_LSB +: TEMP_W]) - 2200) * 10 / 135 + 25);
    drive(0);
    repeat (50) @(posedge clk);
    chk_word("held fault", 32'h0, 32'(faultL));
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    chk_word("after power cycle", 32'h1, 32'(faultL));
    apb(ADDR_CUST1, 1'b1, cfg1(0, 0, 0, 0, 0, 1, 0));
    apb(ADDR_CUST0, 1'b1, cfg0(0, 0, 1) | 32'h1 << C0_OTFDIS);
    overTemp <= 1'b1;
    repeat (10) @(posedge clk);
    chk_word("ot disabled", 32'h1, 32'(faultL));
    apb(ADDR_CUST0, 1'b1, cfg0(0, 0, 1));
    wait_pin(1'b0, n);
    chk_cnt("ot assert", 1, n);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk_word("ot status", {4'h0, temp, 5'h00, 3'b011, 5'h00, 3'b011}, rd);
    overTemp <= 1'b0;
    repeat (20) @(posedge clk);
    chk_word("held ot fault", 32'h0, 32'(faultL));
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_regs;
    t_trim;
    t_qual;
    t_hyst;
    t_side;
    t_latch;
    end_of_test;
  end

  initial begin
    #1000000;
    failures++;
    end_of_test;
  end
endmodule // tb_current_fault_trim_logic
